//--- hdl/epm_ind_mem.sv
// Per-timeslot indirect control store and signaling snapshot store
`timescale 1ns/1ps
`default_nettype none
module epm_ind_mem (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Host indirect port
  input  wire logic       host_we,
  input  wire logic [6:0] host_addr,
  input  wire logic [7:0] host_wdata,
  output logic      [7:0] host_rdata_ff,
  // Timeslot lookup port
  input  wire logic [4:0] slot_ts,
  output logic      [7:0] sub_ff,
  output logic      [7:0] trk_ff,
  output logic      [7:0] sig_ff,
  // Signaling snapshot port
  input  wire logic       snap_we,
  input  wire logic [3:0] snap_wdata,
  output logic      [3:0] snap_ff
);

  logic [7:0] mem_ff  [128];
  logic [3:0] snap_mem_ff [32];

  // One byte per indirect location
  for (genvar i = 0; i < 128; i++) begin : g_ent
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_ff[i] <= 8'h00;
      end else if (host_we && host_addr == 7'(i)) begin
        mem_ff[i] <= host_wdata;
      end
    end
  end

  // One locked nibble per timeslot
  for (genvar j = 0; j < 32; j++) begin : g_snap
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        snap_mem_ff[j] <= 4'h0;
      end else if (snap_we && slot_ts == 5'(j)) begin
        snap_mem_ff[j] <= snap_wdata;
      end
    end
  end

  // Registered read ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_rdata_ff <= 8'h00;
      sub_ff        <= 8'h00;
      trk_ff        <= 8'h00;
      sig_ff        <= 8'h00;
      snap_ff       <= 4'h0;
    end else begin
      host_rdata_ff <= mem_ff[host_addr];
      sub_ff        <= mem_ff[{2'b00, slot_ts}];
      trk_ff        <= mem_ff[{2'b01, slot_ts}];
      sig_ff        <= mem_ff[{2'b10, slot_ts}];
      snap_ff       <= snap_mem_ff[slot_ts];
    end
  end

endmodule : epm_ind_mem
`default_nettype wire

//--- hdl/epm_regs.sv
// E1 monitor overflow, test pattern and transmit payload control register slice
//
// Functional notes
// R1: Counter overflow pulses set sticky flags 7..0 in the first flag register.
// R2: Flags stay set until a one is written to them; zeros change nothing.
// R3: Line code violation overflow sets bit 0 of second register; others reserved.
// R4: Mode 00 selects all 32 timeslots for test, ignoring per-timeslot bits.
// R5: Mode 01 tests all eight bits of timeslots whose test bit is set.
// R6: Mode 10 tests only seven most significant bits of selected timeslots.
// R7: Direction 0 generates toward transmit, checks receive; 1 does the reverse.
// R8: Pattern logic restarts only on a zero-to-one edge of the start bit.
// R9: Busy reads one while an indirect access runs, zero otherwise.
// R10: Host starts no new indirect access while busy reads one.
// R11: Control bit 7 zero writes the data byte, one reads into it.
// R12: Only indirect locations 00-3F, 41-4F and 51-5F are accessible.
// R13: For writes host loads the data register, then writes address with bit 7 zero.
// R14: For reads host writes address with bit 7 one; device returns the byte.
// R15: Snapshot on latches first frame signaling for the whole multiframe; resets one.
// R16: Global trunk enable replaces every timeslot's ABCD with its trunk code.
// R17: Global substitution 000 uses each timeslot's own substitution field.
// R18: Global substitution 001 replaces data with each timeslot's trunk code.
// R19: Global substitution 010 replaces data with A-law milliwatt.
// R20: Global substitution 011 replaces data with mu-law milliwatt.
// R21: Global substitution 100 replaces data with payload loopback data.
// R22: Interrupt output rises when an enabled overflow flag is set.
// R23: Reserved mode and substitution values mean no replacement; reserved bits read zero.
`timescale 1ns/1ps
`default_nettype none
`include "epm_map.svh"
module epm_regs import epm_pkg::*; (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire epm_apb_req_t  apb_req,
  output var  epm_apb_rsp_t  apb_rsp,
  // Counter overflow pulses and interrupt output
  input  wire logic [7:0]    ovf_evt_a,
  input  wire logic          ovf_evt_b,
  output logic               irq,
  // Test pattern generator and checker control
  output var  epm_test_ctl_t test_ctl,
  // Timeslot lookup
  input  wire epm_slot_in_t  slot_in,
  output var  epm_slot_out_t slot_out,
  // Global signaling snapshot enable
  output logic               snap_en
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [9:0]     idx;
  logic           acc_wr;
  logic           setup_rd;
  logic           hit;
  logic [7:0]     wbyte;
  logic [7:0]     nxt_rdata;
  logic [7:0]     ovf_en_a_ff;
  logic           ovf_en_b_ff;
  logic [7:0]     ovf_a_ff;
  logic           ovf_b_ff;
  logic [3:0]     tp_cfg_ff;
  logic           start_prev_ff;
  logic           start_ff;
  logic [7:0]     acc_ctl_ff;
  logic [7:0]     acc_data_ff;
  logic [7:0]     txp_cfg_ff;
  logic [31:0]    prdata_ff;
  epm_acc_state_t state_ff;
  epm_acc_state_t nxt_state;
  logic           busy;
  logic           ind_ok;
  logic           mem_we;
  logic [7:0]     mem_rdata;
  logic [7:0]     sub_q;
  logic [7:0]     trk_q;
  logic [7:0]     sig_q;
  logic [3:0]     snap_q;
  epm_slot_in_t   s1_ff;
  epm_slot_out_t  nxt_out;
  epm_slot_out_t  slot_out_ff;
  epm_tp_mode_t   tp_mode;
  epm_timeslot_substitution_sel_t     gsub;

  // Bus phase decode
  assign idx      = apb_req.paddr[11:2];
  assign wbyte    = apb_req.pwdata[7:0];
  assign acc_wr   = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign setup_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign busy     = (state_ff != EPM_ST_IDLE);
  assign tp_mode  = epm_tp_mode_t'(tp_cfg_ff[`EPM_TP_MODE_LSB +: 2]);
  assign gsub     = epm_timeslot_substitution_sel_t'(txp_cfg_ff[2:0]);

  // Read mux and address hit
  always_comb begin
    hit       = 1'b1;
    nxt_rdata = `EPM_RST_ZERO;
    if (idx == `EPM_IDX_OVF_EN_A) begin
      nxt_rdata = ovf_en_a_ff;
    end else if (idx == `EPM_IDX_OVF_EN_B) begin
      nxt_rdata = {7'h00, ovf_en_b_ff};
    end else if (idx == `EPM_IDX_OVF_A) begin
      nxt_rdata = ovf_a_ff;
    end else if (idx == `EPM_IDX_OVF_B) begin
      nxt_rdata = {7'h00, ovf_b_ff}; // R23
    end else if (idx == `EPM_IDX_TP_CFG) begin
      nxt_rdata = {4'h0, tp_cfg_ff};
    end else if (idx == `EPM_IDX_ACC_STAT) begin
      nxt_rdata = {7'h00, busy}; // R9
    end else if (idx == `EPM_IDX_ACC_CTL) begin
      nxt_rdata = acc_ctl_ff;
    end else if (idx == `EPM_IDX_ACC_DATA) begin
      nxt_rdata = acc_data_ff;
    end else if (idx == `EPM_IDX_TXP_CFG) begin
      nxt_rdata = txp_cfg_ff;
    end else begin
      hit = 1'b0;
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_ff <= {24'h00_0000, nxt_rdata};
    end
  end

  // Zero-wait response, error on unmapped word
  always_comb begin
    apb_rsp.pready  = 1'b1;
    apb_rsp.prdata  = prdata_ff;
    apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit;
  end

  // Overflow interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_en_a_ff <= `EPM_RST_ZERO;
      ovf_en_b_ff <= 1'b0;
    end else if (acc_wr && idx == `EPM_IDX_OVF_EN_A) begin
      ovf_en_a_ff <= wbyte;
    end else if (acc_wr && idx == `EPM_IDX_OVF_EN_B) begin
      ovf_en_b_ff <= wbyte[0];
    end
  end

  // Sticky overflow flags, a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_a_ff <= `EPM_RST_ZERO;
      ovf_b_ff <= 1'b0;
    end else begin
      ovf_a_ff <= (ovf_a_ff & ~((acc_wr && idx == `EPM_IDX_OVF_A) ? wbyte : 8'h00)) | ovf_evt_a; // R1 R2
      ovf_b_ff <= (ovf_b_ff & ~(acc_wr && idx == `EPM_IDX_OVF_B && wbyte[0])) | ovf_evt_b; // R3 R2
    end
  end

  // Interrupt output from enabled flags
  assign irq = |(ovf_a_ff & ovf_en_a_ff) | (ovf_b_ff & ovf_en_b_ff); // R22

  chk_ovf_set_hold: assert property (ovf_evt_a != 8'h00 |=> (ovf_a_ff & $past(ovf_evt_a)) == $past(ovf_evt_a)) // R1
    else $error("overflow event did not set its flag");
  chk_ovf_one_clear: assert property (acc_wr && idx == `EPM_IDX_OVF_A && ovf_evt_a == 8'h00 |=> // R2
    ovf_a_ff == ($past(ovf_a_ff) & ~$past(wbyte))) else $error("write-one-to-clear misbehaved");
  chk_lcv_flag: assert property (ovf_evt_b |=> ovf_b_ff && irq == (ovf_en_b_ff | (|(ovf_a_ff & ovf_en_a_ff)))) // R3
    else $error("line code overflow flag not set");
  chk_irq_raise: assert property ((ovf_evt_a & ovf_en_a_ff) != 8'h00 && !acc_wr |=> irq) // R22
    else $error("enabled overflow did not raise interrupt");
  cov_ovf_clear: cover property (ovf_a_ff != 8'h00 ##1 acc_wr && idx == `EPM_IDX_OVF_A ##1 ovf_a_ff == 8'h00);

  // Test pattern configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tp_cfg_ff <= 4'h0;
    end else if (acc_wr && idx == `EPM_IDX_TP_CFG) begin
      tp_cfg_ff <= 4'(wbyte & `EPM_MASK_TP_CFG);
    end
  end

  // Start pulse on the rising edge of the start bit only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_prev_ff <= 1'b0;
      start_ff      <= 1'b0;
    end else begin
      start_prev_ff <= tp_cfg_ff[`EPM_TP_START_BIT];
      start_ff      <= tp_cfg_ff[`EPM_TP_START_BIT] & ~start_prev_ff; // R8
    end
  end

  // Generator and checker steering
  always_comb begin
    test_ctl.start  = start_ff;
    test_ctl.gen_tx = ~tp_cfg_ff[`EPM_TP_DIR_BIT]; // R7
    test_ctl.gen_rx = tp_cfg_ff[`EPM_TP_DIR_BIT]; // R7
    test_ctl.mode   = tp_mode;
  end

  chk_start_edge: assert property ($rose(tp_cfg_ff[`EPM_TP_START_BIT]) |=> start_ff ##1 !start_ff) // R8
    else $error("start pulse not a single cycle after rising edge");
  chk_start_level: assert property (start_prev_ff && tp_cfg_ff[`EPM_TP_START_BIT] |=> !start_ff) // R8
    else $error("start pulse raised by a held level");
  cov_test_start: cover property (start_ff);

  // Indirect address validity
  always_comb begin
    ind_ok = 1'b0;
    if (acc_ctl_ff[6:0] <= `EPM_IND_TRK_LAST) begin
      ind_ok = 1'b1;
    end else if (acc_ctl_ff[6:0] > `EPM_IND_LAST) begin
      ind_ok = 1'b0;
    end else if (acc_ctl_ff[6:0] == `EPM_IND_SIG_HOLE || acc_ctl_ff[6:0] == `EPM_IND_SIG2_HOLE) begin
      ind_ok = 1'b0;
    end else begin
      ind_ok = 1'b1;
    end
  end

  // Indirect access sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EPM_ST_IDLE: begin
        if (acc_wr && idx == `EPM_IDX_ACC_CTL) begin
          nxt_state = EPM_ST_ACCESS;
        end
      end
      EPM_ST_ACCESS: begin
        nxt_state = acc_ctl_ff[`EPM_ACC_DIR_BIT] ? EPM_ST_LOAD : EPM_ST_IDLE; // R11
      end
      EPM_ST_LOAD: begin
        nxt_state = EPM_ST_IDLE;
      end
      default: begin
        nxt_state = EPM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= EPM_ST_IDLE;
    end else begin
      state_ff <= nxt_state; // R9
    end
  end

  // Control register, frozen while an access runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ctl_ff <= `EPM_RST_ZERO;
    end else if (acc_wr && idx == `EPM_IDX_ACC_CTL && !busy) begin
      acc_ctl_ff <= wbyte; // R10
    end
  end

  // Data register, loaded by host when idle or by a completed read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_data_ff <= `EPM_RST_ZERO;
    end else if (state_ff == EPM_ST_LOAD) begin
      acc_data_ff <= ind_ok ? mem_rdata : 8'h00; // R14 R12
    end else if (acc_wr && idx == `EPM_IDX_ACC_DATA && !busy) begin
      acc_data_ff <= wbyte; // R13
    end
  end

  // Write only to defined locations
  assign mem_we = (state_ff == EPM_ST_ACCESS) & ~acc_ctl_ff[`EPM_ACC_DIR_BIT] & ind_ok; // R11 R12

  chk_busy_read: assert property (state_ff == EPM_ST_IDLE && acc_wr && idx == `EPM_IDX_ACC_CTL
    && wbyte[7] |=> busy [*2] ##1 !busy) else $error("read busy span wrong"); // R9
  chk_busy_write: assert property (state_ff == EPM_ST_IDLE && acc_wr && idx == `EPM_IDX_ACC_CTL
    && !wbyte[7] |=> busy ##1 !busy) else $error("write busy span wrong"); // R9
  chk_read_data: assert property (state_ff == EPM_ST_LOAD |=>
    acc_data_ff == ($past(ind_ok) ? $past(mem_rdata) : 8'h00)) else $error("read data not returned"); // R14
  chk_hole_write: assert property (mem_we |-> ind_ok && !acc_ctl_ff[7]) // R12
    else $error("write to undefined indirect location");
  cov_ind_read: cover property (state_ff == EPM_ST_LOAD ##1 state_ff == EPM_ST_IDLE);

  // Transmit payload global configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txp_cfg_ff <= `EPM_RST_TXP_CFG; // R15
    end else if (acc_wr && idx == `EPM_IDX_TXP_CFG) begin
      txp_cfg_ff <= wbyte & `EPM_MASK_TXP_CFG; // R23
    end
  end

  assign snap_en = txp_cfg_ff[`EPM_CFG_SNAP_BIT];

  // Indirect store and snapshot store
  epm_ind_mem u_mem (
    .pclk          (pclk),
    .presetn       (presetn),
    .host_we       (mem_we),
    .host_addr     (acc_ctl_ff[6:0]),
    .host_wdata    (acc_data_ff),
    .host_rdata_ff (mem_rdata),
    .slot_ts       (slot_in.ts),
    .sub_ff        (sub_q),
    .trk_ff        (trk_q),
    .sig_ff        (sig_q),
    .snap_we       (slot_in.valid && slot_in.frame == 4'h0 && snap_en), // R15
    .snap_wdata    (slot_in.abcd),
    .snap_ff       (snap_q)
  );

  // Stage one aligns the slot with the store outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
    end else begin
      s1_ff <= slot_in;
    end
  end

  // Per-slot decisions from global and per-timeslot settings
  always_comb begin
    nxt_out            = '0;
    nxt_out.valid      = s1_ff.valid;
    nxt_out.ts         = s1_ff.ts;
    nxt_out.trunk_code = trk_q; // R18
    case (gsub)
      EPM_SUB_NONE: begin
        if (sub_q[`EPM_TS_SUB_LSB +: 3] <= 3'h4) begin
          nxt_out.timeslot_substitution_sel = epm_timeslot_substitution_sel_t'(sub_q[`EPM_TS_SUB_LSB +: 3]); // R17
        end else begin
          nxt_out.timeslot_substitution_sel = EPM_SUB_NONE; // R23
        end
      end
      EPM_SUB_TRUNK: nxt_out.timeslot_substitution_sel = EPM_SUB_TRUNK; // R18
      EPM_SUB_ALAW:  nxt_out.timeslot_substitution_sel = EPM_SUB_ALAW; // R19
      EPM_SUB_MULAW: nxt_out.timeslot_substitution_sel = EPM_SUB_MULAW; // R20
      EPM_SUB_LOOP:  nxt_out.timeslot_substitution_sel = EPM_SUB_LOOP; // R21
      default:       nxt_out.timeslot_substitution_sel = EPM_SUB_NONE; // R23
    endcase
    // Timeslots 0 and 16 carry no per-timeslot signaling byte
    if (txp_cfg_ff[`EPM_CFG_GTRK_BIT] || (sig_q[`EPM_TS_STRK_BIT] && s1_ff.ts[3:0] != 4'h0)) begin
      nxt_out.abcd = sig_q[3:0]; // R16
    end else if (snap_en && s1_ff.frame != 4'h0) begin
      nxt_out.abcd = snap_q; // R15
    end else begin
      nxt_out.abcd = s1_ff.abcd;
    end
    case (tp_mode)
      EPM_TP_ALL: nxt_out.test_sel = 1'b1; // R4
      EPM_TP_8BIT: nxt_out.test_sel = sig_q[`EPM_TS_TEST_BIT] && s1_ff.ts[3:0] != 4'h0; // R5
      EPM_TP_7BIT: begin
        nxt_out.test_sel  = sig_q[`EPM_TS_TEST_BIT] && s1_ff.ts[3:0] != 4'h0; // R6
        nxt_out.test_msb7 = nxt_out.test_sel; // R6
      end
      default: nxt_out.test_sel = 1'b0; // R23
    endcase
  end

  // Stage two registers the slot decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_out_ff <= '0;
    end else begin
      slot_out_ff <= nxt_out;
    end
  end

  assign slot_out = slot_out_ff;

  chk_tp_all: assert property (s1_ff.valid && tp_mode == EPM_TP_ALL |=> slot_out_ff.test_sel // R4
    && !slot_out_ff.test_msb7) else $error("unframed mode missed a timeslot");
  chk_tp_rsvd: assert property (tp_mode == EPM_TP_RSVD |=> !slot_out_ff.test_sel) // R23
    else $error("reserved mode selected a timeslot");
  chk_gsub_trunk: assert property (s1_ff.valid && gsub == EPM_SUB_TRUNK |=> // R18
    slot_out_ff.timeslot_substitution_sel == EPM_SUB_TRUNK && slot_out_ff.trunk_code == $past(trk_q))
    else $error("global trunk substitution not applied");
  chk_gtrk_sig: assert property (txp_cfg_ff[`EPM_CFG_GTRK_BIT] && s1_ff.valid |=> // R16
    slot_out_ff.abcd == $past(sig_q[3:0])) else $error("global signaling trunk not applied");
  cov_loopback: cover property (slot_out_ff.valid && slot_out_ff.timeslot_substitution_sel == EPM_SUB_LOOP);

endmodule : epm_regs
`default_nettype wire

//--- inc/epm_map.svh
// Register indices, field positions and reset values of the E1 payload slice
`ifndef EPM_MAP_SVH
`define EPM_MAP_SVH

// Register indices (byte address is four times the index)
`define EPM_IDX_OVF_EN_A   10'h0c3
`define EPM_IDX_OVF_EN_B   10'h0c4
`define EPM_IDX_OVF_A      10'h0c5
`define EPM_IDX_OVF_B      10'h0c6
`define EPM_IDX_TP_CFG     10'h0c7
`define EPM_IDX_ACC_STAT   10'h0c8
`define EPM_IDX_ACC_CTL    10'h0c9
`define EPM_IDX_ACC_DATA   10'h0ca
`define EPM_IDX_TXP_CFG    10'h0cb

// Reset values
`define EPM_RST_ZERO       8'h00
`define EPM_RST_TXP_CFG    8'h80

// Writable bit masks
`define EPM_MASK_OVF_B     8'h01
`define EPM_MASK_TP_CFG    8'h0f
`define EPM_MASK_TXP_CFG   8'hc7

// Field positions
`define EPM_TP_START_BIT   0
`define EPM_TP_DIR_BIT     1
`define EPM_TP_MODE_LSB    2
`define EPM_ACC_DIR_BIT    7
`define EPM_CFG_SNAP_BIT   7
`define EPM_CFG_GTRK_BIT   6
`define EPM_TS_TEST_BIT    6
`define EPM_TS_STRK_BIT    4
`define EPM_TS_SUB_LSB     5

// Indirect address map limits
`define EPM_IND_SUB_LAST   7'h1f
`define EPM_IND_TRK_LAST   7'h3f
`define EPM_IND_SIG_HOLE   7'h40
`define EPM_IND_SIG2_HOLE  7'h50
`define EPM_IND_LAST       7'h5f

`endif

//--- inc/epm_pkg.sv
// Types shared by the E1 payload register slice
package epm_pkg;

  typedef enum logic [2:0] {
    EPM_SUB_NONE  = 3'h0,
    EPM_SUB_TRUNK = 3'h1,
    EPM_SUB_ALAW  = 3'h2,
    EPM_SUB_MULAW = 3'h3,
    EPM_SUB_LOOP  = 3'h4
  } epm_timeslot_substitution_sel_t;

  typedef enum logic [1:0] {
    EPM_TP_ALL  = 2'h0,
    EPM_TP_8BIT = 2'h1,
    EPM_TP_7BIT = 2'h2,
    EPM_TP_RSVD = 2'h3
  } epm_tp_mode_t;

  typedef enum logic [2:0] {
    EPM_ST_IDLE   = 3'b001,
    EPM_ST_ACCESS = 3'b010,
    EPM_ST_LOAD   = 3'b100
  } epm_acc_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } epm_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } epm_apb_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] ts;
    logic [3:0] frame;
    logic [3:0] abcd;
  } epm_slot_in_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] ts;
    epm_timeslot_substitution_sel_t timeslot_substitution_sel;
    logic [7:0] trunk_code;
    logic [3:0] abcd;
    logic       test_sel;
    logic       test_msb7;
  } epm_slot_out_t;

  typedef struct packed {
    logic         start;
    logic         gen_tx;
    logic         gen_rx;
    epm_tp_mode_t mode;
  } epm_test_ctl_t;

endpackage : epm_pkg

//--- verif/epm_host.sv
// APB host model for the E1 payload register slice
`timescale 1ns/1ps
`default_nettype none
`include "epm_map.svh"
module epm_host import epm_pkg::*; (
  // Clock
  input  wire logic         pclk,
  // APB master side
  output var  epm_apb_req_t apb_req,
  input  wire epm_apb_rsp_t apb_rsp,
  // Set when a wait runs out
  output logic              hung
);
  // Idle bus at time zero
  initial begin
    apb_req = '0;
    hung    = 1'b0;
  end

  // One transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, wd}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 100);
    rd  = apb_rsp.prdata[7:0];
    err = apb_rsp.pslverr;
    if (n >= 100) hung = 1'b1;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : xfer

  // Poll the busy bit until it clears
  task automatic wait_idle();
    logic [7:0] s;
    logic       e;
    for (int n = 0; n < 20; n++) begin
      xfer(1'b0, `EPM_IDX_ACC_STAT, 8'h00, s, e);
      if (s[0] === 1'b0) return;
    end
    hung = 1'b1;
  endtask : wait_idle

  // Indirect write: data byte first, then address with direction zero
  task automatic ind_wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    wait_idle();
    xfer(1'b1, `EPM_IDX_ACC_DATA, d, r, e);
    xfer(1'b1, `EPM_IDX_ACC_CTL, {1'b0, a}, r, e);
  endtask : ind_wr

  // Indirect read: address with direction one, then fetch the data byte
  task automatic ind_rd(input logic [6:0] a, output logic [7:0] d);
    logic e;
    wait_idle();
    xfer(1'b1, `EPM_IDX_ACC_CTL, {1'b1, a}, d, e);
    wait_idle();
    xfer(1'b0, `EPM_IDX_ACC_DATA, 8'h00, d, e);
  endtask : ind_rd
endmodule : epm_host
`default_nettype wire

//--- verif/epm_regs_tb.sv
// Self-checking bench for the E1 payload register slice
`timescale 1ns/1ps
`default_nettype none
`include "epm_map.svh"
module epm_regs_tb import epm_pkg::*;;
  logic          pclk, presetn, irq, snap_en, ovf_evt_b, hung, err;
  logic [7:0]    ovf_evt_a, rd;
  logic [31:0]   seed, v, m;
  epm_apb_req_t  apb_req;
  epm_apb_rsp_t  apb_rsp;
  epm_test_ctl_t test_ctl;
  epm_slot_in_t  slot_in;
  epm_slot_out_t slot_out;
  int            n_mismatch, comparisons, flags, fb, gsub, gtrk, mode, pulses, k, ad;
  int            mem [128];

  epm_regs dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .ovf_evt_a(ovf_evt_a), .ovf_evt_b(ovf_evt_b), .irq(irq), .test_ctl(test_ctl),
    .slot_in(slot_in), .slot_out(slot_out), .snap_en(snap_en));
  epm_host host_u (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp), .hung(hung));

  // Free-running 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Start pulse counter and hang cut-off
  always @(posedge pclk) begin
    if (test_ctl.start === 1'b1) pulses++;
    if (hung === 1'b1) begin
      n_mismatch++;
      final_report();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    host_u.xfer(1'b1, idx, d, rd, err);
  endtask : wr

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
    host_u.xfer(1'b0, idx, 8'h00, rd, err);
    chk(rd, exp);
  endtask : rdchk

  // One timeslot lookup compared with the model
  task automatic slot(input logic [4:0] ts, input logic [3:0] fr, input logic [3:0] ab, input logic [3:0] eab);
    int s, sg;
    s = (gsub == 0) ? (mem[ts] >> 5) : gsub;
    if (s > 4) s = 0;
    sg = mem[32'h40 + ts];
    @(posedge pclk);
    slot_in <= '{1'b1, ts, fr, ab};
    @(posedge pclk);
    slot_in.valid <= 1'b0;
    @(posedge pclk);
    #1;
    chk(slot_out.valid, 8'h01);
    chk(slot_out.ts, 8'(ts));
    chk(slot_out.timeslot_substitution_sel, 8'(s));
    chk(slot_out.trunk_code, 8'(mem[32'h20 + ts]));
    chk(slot_out.abcd, (gtrk != 0 || sg[4]) ? sg[3:0] : eab);
    chk(slot_out.test_sel, mode == 0 || ((mode == 1 || mode == 2) && sg[6]));
    chk(slot_out.test_msb7, mode == 2 && sg[6]);
  endtask : slot

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    presetn = 1'b0;
    ovf_evt_a = 8'h00;
    ovf_evt_b = 1'b0;
    slot_in = '0;
    seed = 32'd64;
    n_mismatch = 0;
    comparisons = 0;
    flags = 0;
    fb = 0;
    gsub = 0;
    gtrk = 0;
    mode = 0;
    pulses = 0;
    foreach (mem[i]) mem[i] = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk(snap_en, 8'h01);
    chk(test_ctl.gen_tx, 8'h01);
    rdchk(`EPM_IDX_OVF_A, 8'h00);
    rdchk(`EPM_IDX_TP_CFG, 8'h00);
    rdchk(`EPM_IDX_ACC_STAT, 8'h00);
    rdchk(`EPM_IDX_ACC_CTL, 8'h00);
    rdchk(`EPM_IDX_ACC_DATA, 8'h00);
    rdchk(`EPM_IDX_TXP_CFG, 8'h80);
    rdchk(10'h0ff, 8'h00);
    chk(err, 8'h01);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      m = rnd();
      @(posedge pclk);
      ovf_evt_a <= v[7:0];
      ovf_evt_b <= v[8];
      @(posedge pclk);
      ovf_evt_a <= 8'h00;
      ovf_evt_b <= 1'b0;
      flags = flags | v[7:0];
      fb = fb | v[8];
      rdchk(`EPM_IDX_OVF_A, 8'(flags));
      rdchk(`EPM_IDX_OVF_B, 8'(fb));
      wr(`EPM_IDX_OVF_EN_A, m[15:8]);
      wr(`EPM_IDX_OVF_EN_B, {7'h00, m[24]});
      #1;
      chk(irq, 8'((|(flags & m[15:8])) | (fb & m[24])));
      wr(`EPM_IDX_OVF_A, m[7:0]);
      wr(`EPM_IDX_OVF_B, {7'h7f, m[16]});
      flags = flags & ~m[7:0];
      fb = fb & ~m[16];
      rdchk(`EPM_IDX_OVF_A, 8'(flags));
    end
    $display("test overflow done");
    k = 1 + (rnd() % 15);
    for (int j = 0; j < 3; j++) begin
      ad = j * 32 + k;
      v = rnd();
      mem[ad] = (j == 2) ? (v[7:0] & 8'hef) : v[7:0];
      host_u.ind_wr(7'(ad), 8'(mem[ad]));
    end
    host_u.ind_wr(7'h40, 8'h5a);
    host_u.ind_rd(7'h40, rd);
    chk(rd, 8'h00);
    for (int j = 0; j < 3; j++) begin
      ad = j * 32 + k;
      host_u.ind_rd(7'(ad), rd);
      chk(rd, 8'(mem[ad]));
    end
    $display("test indirect done");
    for (int i = 0; i < 8; i++) begin
      mode = i >> 1;
      wr(`EPM_IDX_TP_CFG, 8'(i << 1));
      #1;
      chk(test_ctl.mode, 8'(mode));
      chk(test_ctl.gen_rx, 8'(i & 1));
      chk(test_ctl.gen_tx, 8'(~i & 1));
      slot(5'(k), 4'h0, 4'h9, 4'h9);
    end
    pulses = 0;
    wr(`EPM_IDX_TP_CFG, 8'h01);
    wr(`EPM_IDX_TP_CFG, 8'h01);
    repeat (4) @(posedge pclk);
    chk(8'(pulses), 8'h01);
    wr(`EPM_IDX_TP_CFG, 8'h00);
    wr(`EPM_IDX_TP_CFG, 8'h01);
    repeat (4) @(posedge pclk);
    chk(8'(pulses), 8'h02);
    mode = 0;
    wr(`EPM_IDX_TP_CFG, 8'h00);
    $display("test pattern done");
    for (int i = 0; i < 16; i++) begin
      gsub = i & 7;
      gtrk = i >> 3;
      wr(`EPM_IDX_TXP_CFG, 8'(8'h80 | (gtrk << 6) | gsub));
      rdchk(`EPM_IDX_TXP_CFG, 8'(8'h80 | (gtrk << 6) | gsub));
      slot(5'(k), 4'h0, 4'h6, 4'h6);
    end
    gsub = 0;
    gtrk = 0;
    wr(`EPM_IDX_TXP_CFG, 8'h80);
    slot(5'(k), 4'h0, 4'h3, 4'h3);
    slot(5'(k), 4'h2, 4'hc, 4'h3);
    wr(`EPM_IDX_TXP_CFG, 8'h00);
    slot(5'(k), 4'h2, 4'hc, 4'hc);
    $display("test payload done");
    final_report();
  end
endmodule : epm_regs_tb
`default_nettype wire
